// ---- osc_tick_model.sv ----
// Far-side model: slow and main oscillators feeding tick pulses to the sequencer
`timescale 1ns/1ps
module osc_tick_model #(
	parameter int LF_DIV  = 8,
	parameter int OSC_DIV = 2
) (
	input  wire logic clock,
	input  wire logic rst,
	output logic      lf_tick,
	output logic      osc_tick
);
	int lf_cnt;
	int osc_cnt;

	// Both oscillators run free; ticks are one clock wide so none is counted twice
	always_ff @(posedge clock) begin
		if (rst) begin
			lf_cnt   <= 0;
			osc_cnt  <= 0;
			lf_tick  <= 1'b0;
			osc_tick <= 1'b0;
		end else begin
			lf_cnt   <= (lf_cnt == LF_DIV - 1) ? 0 : lf_cnt + 1;
			osc_cnt  <= (osc_cnt == OSC_DIV - 1) ? 0 : osc_cnt + 1;
			lf_tick  <= (lf_cnt == LF_DIV - 1);
			osc_tick <= (osc_cnt == OSC_DIV - 1);
		end
	end
endmodule // osc_tick_model

// ---- power_up_brown_out_reset_sequencer_bench.sv ----
// Self-checking bench of the reset sequencer and its register slave
`timescale 1ns/1ps
module power_up_brown_out_reset_sequencer_bench;
	import reset_seq_pkg::*;
	localparam int LF_DIV = 8;
	localparam int OSC_DIV = 2;
	localparam int PW = 4;
	localparam int OS = 4;
	typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] r; logic [1:0] e;} row_t;
	logic clock = 0, rst = 1, por_pulse = 0, supply_below = 0, pin_n = 1;
	logic wdt_timeout = 0, asleep = 0, wake_int = 0, pwdis = 1;
	logic [1:0] mode = BOR_ALWAYS;
	logic [2:0] osc = OSC_EXT_CLK;
	logic lf_tick, osc_tick, core_reset, core_stall, bor_en;
	logic [11:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] d;
	int fails = 0, checked = 0, cyc = 0, n;
	row_t rows[4] = '{'{12'h238, 32'h10, 32'h10, RESP_OKAY},
		'{12'h23c, 32'hff, 32'h18, RESP_OKAY}, '{12'h238, 32'h13, 32'h13, RESP_OKAY},
		'{12'h400, 32'h1, 32'h0, RESP_SLVERR}};

	osc_tick_model #(.LF_DIV(LF_DIV), .OSC_DIV(OSC_DIV)) ticks (.clock(clock), .rst(rst),
		.lf_tick(lf_tick), .osc_tick(osc_tick));

	reset_sequencer #(.POWER_UP_DELAY_TIMER_COUNT(PW), .OST_COUNT(OS), .BOR_CYCLES(2)) DUT (
		.clock(clock), .rst(rst), .por_pulse(por_pulse), .supply_below(supply_below),
		.master_clear_pin_n(pin_n), .wdt_timeout(wdt_timeout), .asleep(asleep),
		.wake_int(wake_int), .lf_tick(lf_tick), .osc_tick(osc_tick),
		.brown_out_mode_select(mode), .power_up_delay_disable_cfg(pwdis), .osc_mode(osc),
		.core_reset(core_reset), .core_stall(core_stall), .bor_detect_en(bor_en),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));

	always #5 clock = ~clock;

	// Cap on the run; all scenarios need well under this
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails = fails + 1;
			give_verdict();
		end
	end

	task automatic give_verdict();
		if (fails == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] r);
		logic ap, wp;
		ap = 1;
		wp = 1;
		@(posedge clock);
		awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
		while (ap || wp) begin
			@(posedge clock);
			if (ap && awready) begin ap = 0; awvalid <= 0; end
			if (wp && wready) begin wp = 0; wvalid <= 0; end
		end
		while (bvalid !== 1'b1) @(posedge clock);
		r = bresp;
		bready <= 0;
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
		@(posedge clock);
		araddr <= a; arvalid <= 1; rready <= 1;
		do @(posedge clock); while (arready !== 1'b1);
		arvalid <= 0;
		do @(posedge clock); while (rvalid !== 1'b1);
		v = rdata;
		r = rresp;
		rready <= 0;
	endtask

	task automatic hold_por();
		por_pulse <= 1;
		repeat (5) @(posedge clock);
		por_pulse <= 0;
	endtask

	// Cycles until the core leaves reset, bounded
	task automatic rel(output int c);
		c = 0;
		while (core_reset !== 1'b0 && c < 5000) begin
			@(posedge clock);
			c++;
		end
	endtask

	initial begin
		repeat (16) @(posedge clock);
		chk("core_reset", 1, core_reset);
		chk("bor_en_rst", 0, bor_en);
		chk("stall_rst", 0, core_stall);
		rst <= 0;
		rd(12'h238, d, resp);
		chk("power_control", 32'h10, d);
		rd(12'h23c, d, resp);
		chk("core_status", 32'h18, d);
		// Register rows: write, response, read back
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w, resp);
			chk("bresp", rows[i].e, resp);
			rd(rows[i].a, d, resp);
			chk("rresp", rows[i].e, resp);
			if (rows[i].e == RESP_OKAY) chk("rdata", rows[i].r, d);
		end
		// Mode decode with the software enable set
		for (int m = 0; m < 4; m++) for (int s = 0; s < 2; s++) begin
			mode <= 2'(m); asleep <= 1'(s);
			repeat (3) @(posedge clock);
			chk("bor_en", m == 3 || (m == 2 && !s) || m == 1, bor_en);
		end
		asleep <= 0;
		wr(12'h238, 32'h03, resp);
		mode <= BOR_SOFTWARE;
		repeat (3) @(posedge clock);
		chk("bor_en_sw", 0, bor_en);
		wr(12'h238, 32'h13, resp);
		// Brown-out, then a second dip in mid-delay; delay kept on
		mode <= BOR_ALWAYS; osc <= OSC_XT; pwdis <= 0;
		supply_below <= 1;
		repeat (4) @(posedge clock);
		supply_below <= 0;
		@(posedge clock);
		chk("bor_reset", 1, core_reset);
		repeat (10) @(posedge clock);
		supply_below <= 1;
		repeat (4) @(posedge clock);
		supply_below <= 0;
		rel(n);
		chk("restart", 1, n >= (PW - 1) * LF_DIV + (OS - 1) * OSC_DIV);
		rd(12'h238, d, resp);
		chk("bor_flags", 32'h12, d);
		// Power-up with delay and crystal count
		hold_por();
		rel(n);
		chk("pwr_up_len", 1, n >= (PW - 1) * LF_DIV + (OS - 1) * OSC_DIV);
		chk("released", 0, core_reset);
		rd(12'h238, d, resp);
		chk("por_n", 0, d & 32'h2);
		// External clock with delay off leaves at once
		osc <= OSC_EXT_CLK; pwdis <= 1;
		hold_por();
		rel(n);
		chk("no_delay", 1, n <= 3);
		// Pin held low past the delays
		osc <= OSC_XT; pwdis <= 0; pin_n <= 0;
		hold_por();
		repeat (200) @(posedge clock);
		chk("pin_hold", 1, core_reset);
		pin_n <= 1;
		rel(n);
		chk("pin_release", 1, n <= 3);
		// Watchdog reset awake, then watchdog wake asleep
		wdt_timeout <= 1;
		@(posedge clock);
		wdt_timeout <= 0;
		@(posedge clock);
		chk("wdt_reset", 1, core_reset);
		rel(n);
		rd(12'h23c, d, resp);
		chk("wdt_flags", 32'h08, d);
		asleep <= 1;
		@(posedge clock);
		wdt_timeout <= 1;
		@(posedge clock);
		wdt_timeout <= 0;
		asleep <= 0;
		@(posedge clock);
		chk("core_stall", 1, core_stall);
		repeat (2) @(posedge clock);
		rd(12'h23c, d, resp);
		chk("wake_flags", 32'h00, d);
		repeat (10) @(posedge clock);
		chk("stall_end", 0, core_stall);
		// Interrupt wake stalls for the start-up count too; no flag moves
		asleep <= 1; wake_int <= 1;
		@(posedge clock);
		asleep <= 0; wake_int <= 0;
		@(posedge clock);
		chk("int_stall", 1, core_stall);
		repeat (12) @(posedge clock);
		// Clear pin in sleep sets timeout and clears only the sleep flag
		asleep <= 1; pin_n <= 0;
		@(posedge clock);
		asleep <= 0; pin_n <= 1;
		@(posedge clock);
		chk("sleep_clr_rst", 1, core_reset);
		rd(12'h23c, d, resp);
		chk("sleep_clr_flags", 32'h10, d);
		// Second reset in mid-run restores reset flags and holds the core
		rst <= 1;
		repeat (2) @(posedge clock);
		rst <= 0;
		chk("rst_hold", 1, core_reset);
		rd(12'h238, d, resp);
		chk("rst_flags", 32'h10, d);
		give_verdict();
	end
endmodule // power_up_brown_out_reset_sequencer_bench

// ---- reset_seq_pkg.sv ----
// Constants, register map and state encoding of the power-up reset sequencer
package reset_seq_pkg;
	// Register indices; byte address is four times the index
	localparam logic [9:0] PWR_CTRL_IDX    = 10'h08e;
	localparam logic [9:0] CORE_STAT_IDX   = 10'h08f;
	// Power control field positions
	localparam int BOR_N_BIT      = 0;
	localparam int POR_N_BIT      = 1;
	localparam int SW_BOR_EN_BIT  = 4;
	// Core status field positions
	localparam int SLEEP_FLAG_BIT = 3;
	localparam int TIMEOUT_BIT    = 4;
	// Reset values of flags
	localparam logic SW_BOR_EN_RST = 1'b1;
	localparam logic BOR_N_RST     = 1'b0;
	localparam logic POR_N_RST     = 1'b0;
	localparam logic TIMEOUT_RST   = 1'b1;
	localparam logic SLEEP_RST     = 1'b1;
	// Brown-out mode field encodings
	localparam logic [1:0] BOR_ALWAYS   = 2'h3;
	localparam logic [1:0] BOR_AWAKE    = 2'h2;
	localparam logic [1:0] BOR_SOFTWARE = 2'h1;
	localparam logic [1:0] BOR_OFF      = 2'h0;
	// Oscillator mode encodings
	localparam logic [2:0] OSC_LP       = 3'h0;
	localparam logic [2:0] OSC_XT       = 3'h1;
	localparam logic [2:0] OSC_HS       = 3'h2;
	localparam logic [2:0] OSC_EXT_CLK  = 3'h3;
	// Timing: power-up delay in the low-frequency oscillator domain
	localparam int CLOCK_MHZ         = 100;
	localparam int POWER_UP_DELAY_TIMER_MS           = 64;
	localparam int LF_OSC_HZ         = 31000;
	localparam int POWER_UP_DELAY_TIMER_LF_CYCLES    = POWER_UP_DELAY_TIMER_MS * LF_OSC_HZ / 1000;
	localparam int OST_PERIODS       = 1024;
	localparam int BOR_MIN_NS        = 100;
	localparam int BOR_MIN_CYCLES    = (BOR_MIN_NS * CLOCK_MHZ + 999) / 1000;
	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_HOLD = 2'b00,
		ST_POWER_UP_DELAY_TIMER = 2'b01,
		ST_OST  = 2'b10,
		ST_RUN  = 2'b11
	} seq_state_t;
endpackage

// ---- reset_sequencer.sv ----
// Power-up, brown-out and reset-cause sequencer with an AXI4-Lite register slave
`timescale 1ns/1ps

// Behaviour
// RL1: Power-on or brown-out reset holds the chip through a nominal 64 ms delay.
// RL2: The power-up delay counts ticks of the 31 kHz low-frequency oscillator.
// RL3: Internal reset stays asserted while the power-up delay runs.
// RL4: Power-up delay disable configuration bit: set disables, cleared enables.
// RL5: Configuring party should enable the delay whenever brown-out reset is used.
// RL6: Brown-out mode 01 follows the software brown-out enable bit.
// RL7: Mode 10 disables brown-out detection asleep; software bit has no effect.
// RL8: Mode decode: 11 on, 10 awake only, 01 software, 00 off.
// RL9: Supply below threshold longer than minimum duration causes brown-out reset.
// RL10: Stay in reset until supply recovers, then run the delay if enabled.
// RL11: Brown-out during the delay returns to reset and restarts the delay.
// RL12: Order is power-on end, power-up delay, then oscillator start-up count.
// RL13: External clock with delay disabled leaves reset without any delay.
// RL14: Delays run independently of the clear pin; release starts execution at once.
// RL15: Crystal modes add 1024 oscillator periods after power-up, brown-out, wake.
// RL16: Power control bit 0 is the active-low brown-out flag, set by software.
// RL17: With brown-out off the brown-out flag value is a don't-care.
// RL18: Power control bit 1 is the active-low power-on flag, set by software.
// RL19: Flags encode cause: power-on, brown-out, watchdog reset, watchdog wake, sleep clear.
// RL20: Delay is a counter of slow oscillator cycles restarted on any reset source; the code restarts it only on power-on and brown-out.
module reset_sequencer
	import reset_seq_pkg::*;
#(
	parameter int POWER_UP_DELAY_TIMER_COUNT = reset_seq_pkg::POWER_UP_DELAY_TIMER_LF_CYCLES,
	parameter int OST_COUNT  = reset_seq_pkg::OST_PERIODS,
	parameter int BOR_CYCLES = reset_seq_pkg::BOR_MIN_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        por_pulse,
	input  wire logic        supply_below,
	input  wire logic        master_clear_pin_n,
	input  wire logic        wdt_timeout,
	input  wire logic        asleep,
	input  wire logic        wake_int,
	input  wire logic        lf_tick,
	input  wire logic        osc_tick,
	input  wire logic [1:0]  brown_out_mode_select,
	input  wire logic        power_up_delay_disable_cfg,
	input  wire logic [2:0]  osc_mode,
	output logic             core_reset,
	output logic             core_stall,
	output logic             bor_detect_en,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	import reset_seq_pkg::*;

	typedef struct packed {
		seq_state_t  state;
		logic [11:0] power_up_delay_timer_cnt;
		logic [11:0] ost_cnt;
		logic [7:0]  bor_cnt;
		logic        bor_trip;
		logic        power_up;
		logic        wake_ost;
		logic        core_reset;
		logic        core_stall;
		logic        bor_en;
		logic        por_n;
		logic        bor_n;
		logic        sw_bor_en;
		logic        timeout;
		logic        sleep_flag;
		logic        aw_got;
		logic [9:0]  aw_idx;
		logic        w_got;
		logic [7:0]  w_byte;
		logic        w_lane;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} seq_regs_t;

	seq_regs_t s_q;
	seq_regs_t s_d;

	// Crystal modes need an oscillator start-up count
	function automatic logic is_crystal(input logic [2:0] mode);
		return (mode == OSC_LP) || (mode == OSC_XT) || (mode == OSC_HS);
	endfunction

	// Brown-out detector enable from the mode field
	function automatic logic bor_enable(input logic [1:0] mode, input logic sleep,
			input logic sw);
		case (mode)
			BOR_ALWAYS:   return 1'b1;
			BOR_AWAKE:    return !sleep;
			BOR_SOFTWARE: return sw;
			default:      return 1'b0;
		endcase
	endfunction

	// Word index from a byte address
	function automatic logic [9:0] word_idx(input logic [11:0] addr);
		return addr[11:2];
	endfunction

	logic wake_event;
	logic wdt_reset;
	logic wdt_wake;
	logic sleep_clear;
	logic bor_rise;
	logic delay_src;
	logic wr_fire;
	logic hw_por_clr;
	logic hw_bor_clr;

	// Sequencer, flags and bus slave next state
	always_comb begin
		s_d = s_q;
		wdt_reset = wdt_timeout && !asleep;
		wdt_wake = wdt_timeout && asleep;
		sleep_clear = !master_clear_pin_n && asleep;
		wake_event = asleep && (wake_int || wdt_wake);

		// Detector enable is registered so the mode decode has one cycle of latency
		s_d.bor_en = bor_enable(brown_out_mode_select, asleep, s_q.sw_bor_en); // RL6 RL7 RL8

		// Qualify a low supply over the minimum duration before tripping
		if (s_q.bor_en && supply_below) begin
			if (s_q.bor_cnt >= 8'(BOR_CYCLES - 1))
				s_d.bor_trip = 1'b1; // RL9
			else
				s_d.bor_cnt = s_q.bor_cnt + 8'h01;
		end else begin
			s_d.bor_cnt = 8'h00;
		end
		// Trip holds until the supply rises back above the threshold
		if (s_q.bor_trip && !supply_below)
			s_d.bor_trip = 1'b0; // RL10
		bor_rise = s_d.bor_trip && !s_q.bor_trip;
		delay_src = por_pulse || s_d.bor_trip;

		// Delay sequence: hold, power-up delay, start-up count, run
		case (s_q.state)
			ST_HOLD: begin
				s_d.power_up_delay_timer_cnt = 12'h000; // RL20
				s_d.ost_cnt = 12'h000;
				if (!delay_src) begin
					if (s_q.power_up && !power_up_delay_disable_cfg)
						s_d.state = ST_POWER_UP_DELAY_TIMER; // RL4 RL10 RL12
					else if (s_q.power_up && is_crystal(osc_mode))
						s_d.state = ST_OST; // RL15
					else
						s_d.state = ST_RUN; // RL13
				end
			end
			ST_POWER_UP_DELAY_TIMER: begin
				if (delay_src) begin
					s_d.state = ST_HOLD; // RL11
					s_d.power_up_delay_timer_cnt = 12'h000;
				end else if (lf_tick) begin
					// Counts slow oscillator ticks only, never the system clock
					if (s_q.power_up_delay_timer_cnt == 12'(POWER_UP_DELAY_TIMER_COUNT - 1))
						s_d.state = is_crystal(osc_mode) ? ST_OST : ST_RUN; // RL1 RL2 RL12
					else
						s_d.power_up_delay_timer_cnt = s_q.power_up_delay_timer_cnt + 12'h001;
				end
			end
			ST_OST: begin
				if (delay_src) begin
					s_d.state = ST_HOLD;
				end else if (osc_tick) begin
					if (s_q.ost_cnt == 12'(OST_COUNT - 1))
						s_d.state = ST_RUN; // RL15
					else
						s_d.ost_cnt = s_q.ost_cnt + 12'h001;
				end
			end
			ST_RUN: begin
				if (delay_src)
					s_d.state = ST_HOLD;
			end
			default: s_d.state = ST_HOLD;
		endcase
		// Power-up case remembered so clear-pin and watchdog resets skip the delays
		if (delay_src)
			s_d.power_up = 1'b1; // RL1
		else if (s_d.state == ST_RUN)
			s_d.power_up = 1'b0;

		// Wake from sleep in crystal mode stalls the core for the start-up count
		if (delay_src) begin
			s_d.wake_ost = 1'b0;
		end else if (s_q.wake_ost) begin
			if (osc_tick && s_q.ost_cnt == 12'(OST_COUNT - 1))
				s_d.wake_ost = 1'b0; // RL15
			else if (osc_tick)
				s_d.ost_cnt = s_q.ost_cnt + 12'h001;
		end else if (s_q.state == ST_RUN && wake_event && is_crystal(osc_mode)) begin
			s_d.wake_ost = 1'b1;
			s_d.ost_cnt = 12'h000;
		end
		s_d.core_stall = s_d.wake_ost;

		// Delays run from power-on regardless of the pin; pin only gates the release
		s_d.core_reset = (s_d.state != ST_RUN) || !master_clear_pin_n || wdt_reset; // RL3 RL14

		// AXI write address and data are accepted in either order
		if (s_q.awready && s_axi_awvalid) begin
			s_d.aw_got = 1'b1;
			s_d.aw_idx = word_idx(s_axi_awaddr);
		end
		if (s_q.wready && s_axi_wvalid) begin
			s_d.w_got = 1'b1;
			s_d.w_byte = s_axi_wdata[7:0];
			s_d.w_lane = s_axi_wstrb[0];
		end
		wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
		if (wr_fire) begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = (s_q.aw_idx == PWR_CTRL_IDX || s_q.aw_idx == CORE_STAT_IDX) ?
				RESP_OKAY : RESP_SLVERR;
		end else if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end

		// Software writes to power control; only low byte lane carries data
		if (wr_fire && s_q.aw_idx == PWR_CTRL_IDX && s_q.w_lane) begin
			s_d.por_n = s_q.w_byte[POR_N_BIT]; // RL18
			s_d.bor_n = s_q.w_byte[BOR_N_BIT]; // RL16
			s_d.sw_bor_en = s_q.w_byte[SW_BOR_EN_BIT]; // RL6
		end

		// Hardware cause recording; these come last so a hardware clear beats a software write
		hw_por_clr = por_pulse;
		hw_bor_clr = bor_rise && !por_pulse;
		if (hw_por_clr) begin
			s_d.por_n = 1'b0; // RL18 RL19
			s_d.timeout = 1'b1;
			s_d.sleep_flag = 1'b1;
		end else if (hw_bor_clr) begin
			s_d.bor_n = 1'b0; // RL16 RL19
			s_d.timeout = 1'b1;
			s_d.sleep_flag = 1'b1;
		end else if (wdt_wake) begin
			s_d.timeout = 1'b0; // RL19
			s_d.sleep_flag = 1'b0;
		end else if (wdt_reset) begin
			s_d.timeout = 1'b0; // RL19
		end else if (sleep_clear) begin
			s_d.timeout = 1'b1; // RL19
			s_d.sleep_flag = 1'b0;
		end

		// Read channel; data sampled at the address handshake
		if (s_q.arready && s_axi_arvalid) begin
			s_d.rvalid = 1'b1;
			s_d.rdata = 32'h0000_0000;
			s_d.rresp = RESP_OKAY;
			case (word_idx(s_axi_araddr))
				PWR_CTRL_IDX: begin
					s_d.rdata[POR_N_BIT] = s_q.por_n;
					s_d.rdata[BOR_N_BIT] = s_q.bor_n; // RL17
					s_d.rdata[SW_BOR_EN_BIT] = s_q.sw_bor_en;
				end
				CORE_STAT_IDX: begin
					s_d.rdata[TIMEOUT_BIT] = s_q.timeout;
					s_d.rdata[SLEEP_FLAG_BIT] = s_q.sleep_flag;
				end
				default: s_d.rresp = RESP_SLVERR;
			endcase
		end else if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end

		// Readies registered from next state so outputs come from flops
		s_d.awready = !s_d.aw_got && !s_d.bvalid;
		s_d.wready = !s_d.w_got && !s_d.bvalid;
		s_d.arready = !s_d.rvalid;
	end

	// State register with synchronous reset
	always_ff @(posedge clock) begin
		if (rst) begin
			s_q <= '0;
			s_q.state <= ST_HOLD;
			s_q.power_up <= 1'b1;
			s_q.core_reset <= 1'b1;
			s_q.por_n <= POR_N_RST;
			s_q.bor_n <= BOR_N_RST;
			s_q.sw_bor_en <= SW_BOR_EN_RST;
			s_q.timeout <= TIMEOUT_RST;
			s_q.sleep_flag <= SLEEP_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign core_reset    = s_q.core_reset;
	assign core_stall    = s_q.core_stall;
	assign bor_detect_en = s_q.bor_en;
	assign s_axi_awready = s_q.awready;
	assign s_axi_wready  = s_q.wready;
	assign s_axi_bvalid  = s_q.bvalid;
	assign s_axi_bresp   = s_q.bresp;
	assign s_axi_arready = s_q.arready;
	assign s_axi_rvalid  = s_q.rvalid;
	assign s_axi_rdata   = s_q.rdata;
	assign s_axi_rresp   = s_q.rresp;

	// Checks on sequencing and flag behaviour
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	power_up_delay_timer_holds_a: assert property (s_q.state == ST_POWER_UP_DELAY_TIMER |-> s_q.core_reset) // RL3
		else $error("core released while power-up delay runs");
	power_up_delay_timer_length_a: assert property ($past(s_q.state) == ST_POWER_UP_DELAY_TIMER && s_q.state inside {ST_OST, ST_RUN}
		|-> $past(s_q.power_up_delay_timer_cnt) == 12'(POWER_UP_DELAY_TIMER_COUNT - 1) && $past(lf_tick)) // RL1 RL2
		else $error("power-up delay ended at wrong count");
	bor_restart_a: assert property (s_q.state == ST_POWER_UP_DELAY_TIMER && s_d.bor_trip
		|=> s_q.state == ST_HOLD && s_q.power_up_delay_timer_cnt == 12'h000) // RL11
		else $error("brown-out did not restart power-up delay");
	mode_off_a: assert property (brown_out_mode_select == BOR_OFF |=> !bor_detect_en) // RL8
		else $error("detector enabled in off mode");
	sleep_gate_a: assert property (brown_out_mode_select == BOR_AWAKE && asleep
		|=> !bor_detect_en) // RL7
		else $error("detector enabled asleep in awake-only mode");
	sw_mode_a: assert property (brown_out_mode_select == BOR_SOFTWARE
		|=> bor_detect_en == $past(s_q.sw_bor_en)) // RL6
		else $error("detector ignores software enable");
	por_flag_a: assert property (por_pulse |=> !s_q.por_n && s_q.core_reset) // RL18
		else $error("power-on flag not cleared");
	bor_flag_a: assert property (s_d.bor_trip && !s_q.bor_trip && !por_pulse |=> !s_q.bor_n) // RL16
		else $error("brown-out flag not cleared");
	no_delay_a: assert property (s_q.state == ST_HOLD && !por_pulse && !s_d.bor_trip
		&& osc_mode == OSC_EXT_CLK && power_up_delay_disable_cfg |=> s_q.state == ST_RUN) // RL13
		else $error("external clock mode applied a delay");
	wdt_flag_a: assert property (wdt_timeout && !asleep && !por_pulse && !s_d.bor_trip
		|=> !s_q.timeout) // RL19
		else $error("watchdog reset did not clear timeout flag");
	// Sleep wake and clear pin paths; wake moves the stall, the clear pin moves flags and core reset
	wake_stall_a: assert property (s_q.state == ST_RUN && !s_q.wake_ost && asleep && wake_int
		&& !s_d.bor_trip && !por_pulse && is_crystal(osc_mode) |=> core_stall) // RL15
		else $error("wake in crystal mode did not stall the core");
	sleep_clr_a: assert property (!master_clear_pin_n && asleep && !wdt_timeout && !por_pulse
		&& !s_d.bor_trip |=> s_q.timeout && !s_q.sleep_flag) // RL19
		else $error("clear pin in sleep set wrong flags");
	pin_hold_a: assert property (!master_clear_pin_n |=> core_reset) // RL14
		else $error("core released while clear pin low");

	full_powerup_c: cover property (s_q.state == ST_POWER_UP_DELAY_TIMER ##1 s_q.state == ST_OST);
	ost_done_c: cover property (s_q.state == ST_OST ##1 s_q.state == ST_RUN);
	bor_in_delay_c: cover property (s_q.state == ST_POWER_UP_DELAY_TIMER ##1 s_q.state == ST_HOLD);
	wake_stall_c: cover property ($rose(s_q.core_stall));
endmodule // reset_sequencer
